// file: include/cgid_defs.vh
// Constants for the geometry identify and opcode decode block.
// Assumes inclusion by bare name from the design files.
`ifndef CGID_DEFS_VH
`define CGID_DEFS_VH

// ****************************************************************
// Wishbone register byte offsets
// ****************************************************************
`define CGID_OFF_CMD 8'h00
`define CGID_OFF_PARAM 8'h04
`define CGID_OFF_STATUS 8'h08
`define CGID_OFF_CLASS 8'h0c
`define CGID_OFF_IDADDR 8'h10
`define CGID_OFF_IDDATA 8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define CGID_PARAM_SEC_LSB 0
`define CGID_PARAM_HEAD_LSB 8
`define CGID_STAT_ERR_BIT 0
`define CGID_STAT_BUSY_BIT 1
`define CGID_STAT_VALID_BIT 2
`define CGID_STAT_INIT_BIT 3
`define CGID_STAT_ABRT_BIT 4

// ****************************************************************
// Capacity thresholds and limits
// ****************************************************************
`define CGID_SMALL_CAP 32'd1032192
`define CGID_LARGE_CAP 32'd16515072
`define CGID_SMALL_CYL_MAX 16'd1024
`define CGID_MAX_HEADS 16'd16
`define CGID_MAX_SPT 16'd63
`define CGID_CYL_SAT 16'hffff
`define CGID_CYL_CAP_H4 16'hffff
`define CGID_CYL_CAP_H8 16'h7fff
`define CGID_CYL_CAP_H16 16'h3fff

// ****************************************************************
// Identify word indices
// ****************************************************************
`define CGID_W_DCYL 8'd1
`define CGID_W_DHEAD 8'd3
`define CGID_W_DSPT 8'd6
`define CGID_W_VALID 8'd53
`define CGID_W_CCYL 8'd54
`define CGID_W_CHEAD 8'd55
`define CGID_W_CSPT 8'd56
`define CGID_W_CCAPL 8'd57
`define CGID_W_CCAPH 8'd58
`define CGID_W_LBAL 8'd60
`define CGID_W_LBAH 8'd61

// ****************************************************************
// Command classes
// ****************************************************************
`define CGID_CL_RESERVED 5'd0
`define CGID_CL_VENDOR 5'd1
`define CGID_CL_NOP 5'd2
`define CGID_CL_RECAL 5'd3
`define CGID_CL_READ 5'd4
`define CGID_CL_WRITE 5'd5
`define CGID_CL_SEEK 5'd6
`define CGID_CL_INITP 5'd7
`define CGID_CL_IDENT 5'd8
`define CGID_CL_MULT 5'd9
`define CGID_CL_DMA 5'd10
`define CGID_CL_POWER 5'd11
`define CGID_CL_OTHER 5'd12

`endif

// file: design/cgid_opdec.v
// Combinational opcode classifier: class, variant and alias resolution.
// Assumes the caller registers the outputs.
`timescale 1ns/1ps
`include "cgid_defs.vh"
module cgid_opdec (
  input wire [7:0] op_i,
  output reg [4:0] class_o,
  output reg variant_o,
  output reg [7:0] canon_o
);
  always @* begin
    class_o = `CGID_CL_RESERVED;
    variant_o = 1'b0;
    canon_o = op_i;
    if (op_i[7:4] == 4'h1) begin
      class_o = `CGID_CL_RECAL;
      canon_o = 8'h10;
    end else if (op_i[7:4] == 4'h7) begin
      class_o = `CGID_CL_SEEK;
      canon_o = 8'h70;
    end else if (op_i[7:4] == 4'h8 || op_i[7:4] == 4'hf ||
                 (op_i[7:2] == 6'h30) || op_i == 8'h9a) begin
      class_o = `CGID_CL_VENDOR;
    end else if (op_i[7:2] == 6'h08) begin
      class_o = `CGID_CL_READ;
      variant_o = op_i[0];
    end else if (op_i[7:2] == 6'h0c) begin
      class_o = `CGID_CL_WRITE;
      variant_o = op_i[0];
    end else if (op_i >= 8'h94 && op_i <= 8'h99) begin
      class_o = `CGID_CL_POWER;
      case (op_i)
        8'h94: canon_o = 8'he0;
        8'h95: canon_o = 8'he1;
        8'h96: canon_o = 8'he2;
        8'h97: canon_o = 8'he3;
        8'h98: canon_o = 8'he5;
        default: canon_o = 8'he6;
      endcase
    end else if ((op_i >= 8'he0 && op_i <= 8'he3) || op_i == 8'he5 || op_i == 8'he6) begin
      class_o = `CGID_CL_POWER;
    end else if (op_i >= 8'hc4 && op_i <= 8'hc6) begin
      class_o = `CGID_CL_MULT;
    end else if (op_i[7:2] == 6'h32) begin
      class_o = `CGID_CL_DMA;
      variant_o = op_i[0];
    end else if (op_i == 8'h91) begin
      class_o = `CGID_CL_INITP;
    end else if (op_i == 8'hec) begin
      class_o = `CGID_CL_IDENT;
    end else if (op_i == 8'h00) begin
      class_o = `CGID_CL_NOP;
    end else begin
      case (op_i)
        8'h08, 8'h3c, 8'h40, 8'h41, 8'h50, 8'h90, 8'h92, 8'ha0, 8'ha1, 8'ha2,
        8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hdf, 8'he4, 8'he8, 8'he9, 8'hea, 8'heb,
        8'hed, 8'hee, 8'hef: class_o = `CGID_CL_OTHER;
        default: class_o = `CGID_CL_RESERVED;
      endcase
    end
  end
endmodule // cgid_opdec

// file: design/cgid_div.v
// Sequential restoring divider, 32 by 16, one quotient bit a cycle.
// Assumes start_i is a one-cycle pulse while idle; divisor nonzero.
`timescale 1ns/1ps
module cgid_div (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire [31:0] dividend_i,
  input wire [15:0] divisor_i,
  output reg done_o,
  output reg [31:0] quot_o
);
  reg [31:0] rem_reg;
  reg [31:0] q_reg;
  reg [15:0] dv_reg;
  reg [5:0] cnt_reg;
  reg busy_reg;
  wire [32:0] trial;
  assign trial = {rem_reg, q_reg[31]} - {17'h00000, dv_reg};
  always @(posedge clk_i) begin
    if (rst_i) begin
      rem_reg <= 32'h00000000;
      q_reg <= 32'h00000000;
      dv_reg <= 16'h0000;
      cnt_reg <= 6'h00;
      busy_reg <= 1'b0;
      done_o <= 1'b0;
      quot_o <= 32'h00000000;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_reg) begin
        rem_reg <= 32'h00000000;
        q_reg <= dividend_i;
        dv_reg <= divisor_i;
        cnt_reg <= 6'd32;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (!trial[32]) begin
          rem_reg <= trial[31:0];
          q_reg <= {q_reg[30:0], 1'b1};
        end else begin
          rem_reg <= {rem_reg[30:0], q_reg[31]};
          q_reg <= {q_reg[30:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 6'd1;
        if (cnt_reg == 6'd1) begin
          busy_reg <= 1'b0;
          done_o <= 1'b1;
          quot_o <= trial[32] ? {q_reg[30:0], 1'b0} : {q_reg[30:0], 1'b1};
        end
      end
    end
  end
endmodule // cgid_div

// file: design/cgid_geom.v
// Geometry identify words and opcode decode behind a Wishbone slave.
// Assumes one clock, synchronous reset and a classic Wishbone master.
// Notes on behaviour
// - small drives report at most 1024 default cylinders
// - above small threshold, default cylinders capped by default head count
// - default heads never above 16
// - default sectors per track at most 63
// - default geometry words never change
// - current geometry words 53-58 always provided
// - validity bit set in supported mode
// - unsupported mode clears validity and words 54-58
// - before init, current equals default geometry
// - current cylinders equal sectors divided, saturated
// - current heads from last init, 1-16
// - current sectors from last init, 1-255
// - words 57-58 hold cylinders times heads times sectors
// - CHS capacity never above LBA total
// - LBA total in words 60-61, constant
// - orphan sectors refused under CHS here
// - default geometry keeps orphans small
// - LBA supported above small threshold
// - 1xh recalibrate, 7xh seek
// - 20h-23h reads, 30h-33h writes, odd no-retry
// - 94h-99h alias power commands E0h-E6h
// - multiple, DMA, init params, identify distinct
// - 80h-8Fh, C0h-C3h, F0h-FFh vendor unique
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "cgid_defs.vh"
module cgid_geom #(
  parameter [31:0] LBA_SECTORS = 32'd1048320,
  parameter [15:0] DEF_HEADS = 16'd16,
  parameter [15:0] DEF_SPT = 16'd63
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg busy_o,
  output reg err_o
);

  // ****************************************************************
  // Default geometry, fixed at elaboration
  // ****************************************************************
  function [15:0] cyl_cap;
    input [15:0] heads;
    begin
      if (heads <= 16'd4)
        cyl_cap = `CGID_CYL_CAP_H4;
      else if (heads <= 16'd8)
        cyl_cap = `CGID_CYL_CAP_H8;
      else
        cyl_cap = `CGID_CYL_CAP_H16;
    end
  endfunction

  // Clamp heads and sectors so a bad parameter cannot break the limits
  localparam [15:0] DH = (DEF_HEADS > `CGID_MAX_HEADS) ? `CGID_MAX_HEADS :
                         ((DEF_HEADS == 16'd0) ? 16'd1 : DEF_HEADS);
  localparam [15:0] DS = (DEF_SPT > `CGID_MAX_SPT) ? `CGID_MAX_SPT :
                         ((DEF_SPT == 16'd0) ? 16'd1 : DEF_SPT);
  // Truncated quotient keeps orphans below one cylinder
  localparam [31:0] DC_RAW = LBA_SECTORS / ({16'h0000, DH} * {16'h0000, DS});
  localparam [31:0] DC_LIM = (LBA_SECTORS <= `CGID_SMALL_CAP) ?
                             {16'h0000, `CGID_SMALL_CYL_MAX} :
                             {16'h0000, cyl_cap(DH)};
  localparam [15:0] DC = (DC_RAW > DC_LIM) ? DC_LIM[15:0] : DC_RAW[15:0];

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_DIV = 2'd1;
  localparam [1:0] ST_FIN = 2'd2;

  reg [1:0] state_reg;
  reg [7:0] op_reg;
  reg [15:0] param_reg;
  reg [15:0] cur_cyl_reg;
  reg [15:0] cur_head_reg;
  reg [15:0] cur_spt_reg;
  reg [31:0] cur_cap_reg;
  reg valid_reg;
  reg init_done_reg;
  reg abort_reg;
  reg [4:0] class_reg;
  reg variant_reg;
  reg [7:0] canon_reg;
  reg [7:0] id_addr_reg;
  reg div_start_reg;
  reg [15:0] pend_head_reg;
  reg [15:0] pend_spt_reg;

  wire [4:0] dec_class;
  wire dec_variant;
  wire [7:0] dec_canon;
  wire div_done;
  wire [31:0] div_quot;
  wire wb_req;
  wire [15:0] id_word;

  assign wb_req = cyc_i && stb_i && !ack_o;

  cgid_opdec u_dec (
    .op_i(dat_i[7:0]),
    .class_o(dec_class),
    .variant_o(dec_variant),
    .canon_o(dec_canon)
  );

  cgid_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(div_start_reg),
    .dividend_i(LBA_SECTORS),
    .divisor_i(pend_head_reg * pend_spt_reg),
    .done_o(div_done),
    .quot_o(div_quot)
  );

  // ****************************************************************
  // Identify word lookup
  // ****************************************************************
  function [15:0] id_lookup;
    input [7:0] idx;
    begin
      case (idx)
        `CGID_W_DCYL: id_lookup = DC;
        `CGID_W_DHEAD: id_lookup = DH;
        `CGID_W_DSPT: id_lookup = DS;
        `CGID_W_VALID: id_lookup = {15'h0000, valid_reg};
        `CGID_W_CCYL: id_lookup = cur_cyl_reg;
        `CGID_W_CHEAD: id_lookup = cur_head_reg;
        `CGID_W_CSPT: id_lookup = cur_spt_reg;
        `CGID_W_CCAPL: id_lookup = cur_cap_reg[15:0];
        `CGID_W_CCAPH: id_lookup = cur_cap_reg[31:16];
        `CGID_W_LBAL: id_lookup = LBA_SECTORS[15:0];
        `CGID_W_LBAH: id_lookup = LBA_SECTORS[31:16];
        default: id_lookup = 16'h0000;
      endcase
    end
  endfunction

  assign id_word = id_lookup(id_addr_reg);

  // ****************************************************************
  // Command execution and register writes
  // ****************************************************************
  wire mode_ok;
  wire [31:0] sat_cyl;
  // Zero sectors cannot be translated; counted as unsupported
  assign mode_ok = (param_reg[7:0] != 8'h00);
  assign sat_cyl = (div_quot > {16'h0000, `CGID_CYL_SAT}) ?
                   {16'h0000, `CGID_CYL_SAT} : div_quot;

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      op_reg <= 8'h00;
      param_reg <= {4'h0, 4'h0, 8'h00};
      cur_cyl_reg <= DC;
      cur_head_reg <= DH;
      cur_spt_reg <= DS;
      cur_cap_reg <= {16'h0000, DC} * {16'h0000, DH} * {16'h0000, DS};
      valid_reg <= 1'b1;
      init_done_reg <= 1'b0;
      abort_reg <= 1'b0;
      class_reg <= `CGID_CL_RESERVED;
      variant_reg <= 1'b0;
      canon_reg <= 8'h00;
      id_addr_reg <= 8'h00;
      div_start_reg <= 1'b0;
      pend_head_reg <= 16'd1;
      pend_spt_reg <= 16'd1;
      busy_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      div_start_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (wb_req && we_i && adr_i == `CGID_OFF_PARAM && sel_i[1:0] == 2'b11) begin
            param_reg <= {4'h0, dat_i[`CGID_PARAM_HEAD_LSB +: 4], dat_i[7:0]};
          end
          if (wb_req && we_i && adr_i == `CGID_OFF_IDADDR && sel_i[0]) begin
            id_addr_reg <= dat_i[7:0];
          end
          if (wb_req && we_i && adr_i == `CGID_OFF_CMD && sel_i[0]) begin
            op_reg <= dat_i[7:0];
            class_reg <= dec_class;
            variant_reg <= dec_variant;
            canon_reg <= dec_canon;
            abort_reg <= 1'b0;
            err_o <= 1'b0;
            if (dec_class == `CGID_CL_RESERVED) begin
              abort_reg <= 1'b1;
              err_o <= 1'b1;
            end else if (dec_class == `CGID_CL_INITP) begin
              if (mode_ok) begin
                pend_head_reg <= {12'h000, param_reg[11:8]} + 16'd1;
                pend_spt_reg <= {8'h00, param_reg[7:0]};
                div_start_reg <= 1'b1;
                busy_o <= 1'b1;
                state_reg <= ST_DIV;
              end else begin
                valid_reg <= 1'b0;
                cur_cyl_reg <= 16'h0000;
                cur_head_reg <= 16'h0000;
                cur_spt_reg <= 16'h0000;
                cur_cap_reg <= 32'h00000000;
                init_done_reg <= 1'b1;
              end
            end
          end
        end
        ST_DIV: begin
          if (div_done) begin
            cur_cyl_reg <= sat_cyl[15:0];
            cur_head_reg <= pend_head_reg;
            cur_spt_reg <= pend_spt_reg;
            state_reg <= ST_FIN;
          end
        end
        ST_FIN: begin
          // Floor division makes the product fit the LBA total
          cur_cap_reg <= cur_cyl_reg * cur_head_reg * cur_spt_reg;
          valid_reg <= 1'b1;
          init_done_reg <= 1'b1;
          busy_o <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Wishbone read path and acknowledge
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= wb_req;
      if (wb_req && !we_i) begin
        case (adr_i)
          `CGID_OFF_CMD: dat_o <= {24'h000000, op_reg};
          `CGID_OFF_PARAM: dat_o <= {16'h0000, param_reg};
          `CGID_OFF_STATUS: dat_o <= {27'h0000000, abort_reg, init_done_reg, valid_reg,
                                      busy_o, err_o};
          `CGID_OFF_CLASS: dat_o <= {16'h0000, canon_reg, 2'b00, variant_reg, class_reg};
          `CGID_OFF_IDADDR: dat_o <= {24'h000000, id_addr_reg};
          `CGID_OFF_IDDATA: dat_o <= {16'h0000, id_word};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // cgid_geom

// file: verif/cgid_geom_asserts.sv
// Checker for the geometry identify block, bound to its top ports.
// Assumes one clock, synchronous active-high reset and classic Wishbone.
`timescale 1ns/1ps
`include "cgid_defs.vh"
module cgid_geom_asserts (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire busy_o,
  input wire err_o
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  wire taken = cyc_i && stb_i && !ack_o;
  wire cmd_wr = taken && we_i && adr_i == `CGID_OFF_CMD && sel_i[0] && !busy_o;
  wire rsvd_op = dat_i[7:4] == 4'h6 || dat_i[7:4] == 4'hb;
  // Zero sector count skips the divider, so no busy is owed then
  reg [7:0] sec_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      sec_reg <= 8'h3f;
    end else if (taken && we_i && adr_i == `CGID_OFF_PARAM && sel_i[1:0] == 2'b11 && !busy_o) begin
      sec_reg <= dat_i[7:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence s_init_cmd;
    cmd_wr && dat_i[7:0] == 8'h91 && sec_reg != 8'h00;
  endsequence
  sequence s_busy_run;
    busy_o [*8];
  endsequence
  property p_busy_rise;
    disable iff (rst_i) s_init_cmd |-> ##[1:3] s_busy_run;
  endproperty
  property p_busy_end;
    disable iff (rst_i) $rose(busy_o) |-> ##[8:60] !busy_o;
  endproperty
  property p_busy_cause;
    disable iff (rst_i) $rose(busy_o) |-> $past(cmd_wr) || $past(cmd_wr, 2);
  endproperty
  property p_err_rsvd;
    disable iff (rst_i) cmd_wr && rsvd_op |-> ##[1:3] err_o;
  endproperty
  property p_err_cause;
    disable iff (rst_i) $rose(err_o) |-> $past(cmd_wr) || $past(cmd_wr, 2);
  endproperty
  property p_ack_one;
    disable iff (rst_i) taken |=> ack_o;
  endproperty
  property p_ack_pulse;
    disable iff (rst_i) ack_o |=> !ack_o;
  endproperty
  property p_ack_cause;
    disable iff (rst_i) ack_o |-> $past(cyc_i && stb_i);
  endproperty
  property p_rdata_hold;
    disable iff (rst_i) $changed(dat_o) && !$past(rst_i) |-> ack_o && !we_i;
  endproperty
  property p_reset;
    rst_i |=> !ack_o && !busy_o && !err_o && dat_o == 32'h0;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("no busy after init");
  a_busy_end: assert property (p_busy_end) else $error("busy out of bounds");
  a_busy_cause: assert property (p_busy_cause) else $error("busy without cmd");
  a_err_rsvd: assert property (p_err_rsvd) else $error("reserved not aborted");
  a_err_cause: assert property (p_err_cause) else $error("err without cmd");
  a_ack_one: assert property (p_ack_one) else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_reset: assert property (p_reset) else $error("bad reset outputs");
endmodule // cgid_geom_asserts

// file: verif/cgid_host_model.sv
// Host controller model: classic Wishbone master issuing commands.
// Assumes the slave acks each request; the bench bounds the wait.
`timescale 1ns/1ps
module cgid_host_model (
  input wire clk_i,
  input wire ack_i,
  input wire [31:0] dat_i,
  output reg cyc_o,
  output reg stb_o,
  output reg we_o,
  output reg [7:0] adr_o,
  output reg [3:0] sel_o,
  output reg [31:0] dat_o
);
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // Released address, data and select lines turn inverse so stale values never pass as held
  task automatic xfer(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    sel_o <= s;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
    sel_o <= ~s;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s);
    xfer(1'b1, a, d, s);
  endtask
  // Reads drive write low, zero data and all four byte selects
  task automatic rd(input [7:0] a);
    xfer(1'b0, a, 32'h0, 4'hf);
  endtask
endmodule // cgid_host_model

// file: verif/tb_top.sv
// Self-checking bench for the geometry identify and decode block.
// Assumes the host model and checker are compiled alongside.
`timescale 1ns/1ps
`include "cgid_defs.vh"
module tb_top;
  localparam [31:0] LBA = 32'd1048320;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  wire cyc, stb, we, ack, busy, err;
  wire [7:0] adr;
  wire [3:0] sel;
  wire [31:0] wdat, rdat;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int miscompares = 0;
  int cmp_count = 0;
  reg [31:0] seed = 32'hed51bd06;
  initial forever #10 clk_i = ~clk_i;
  cgid_geom #(.LBA_SECTORS(LBA), .DEF_HEADS(16'd16), .DEF_SPT(16'd63)) cgid_geom_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .busy_o(busy), .err_o(err));
  cgid_host_model cgid_host_model_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic cmp(input [31:0] got, input [31:0] ev, input [31:0] m);
    cmp_count++;
    if ((got & m) !== (ev & m)) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got & m, ev & m);
    end
  endtask
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) cmp(rdat, ~rdat, 32'hffffffff);
      else cmp(rdat, exp_q.pop_front(), msk_q.pop_front());
    end
  end
  task automatic chk(input [7:0] a, input [31:0] e, input [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    cgid_host_model_inst.rd(a);
  endtask
  task automatic idw(input [7:0] w, input [31:0] e, input [31:0] m);
    cgid_host_model_inst.wr(`CGID_OFF_IDADDR, {24'h0, w}, 4'hf);
    chk(`CGID_OFF_IDDATA, e, m);
  endtask
  // Stray PARAM write lands while busy and must be dropped
  task automatic init(input [15:0] h, input [7:0] s, input stray);
    cgid_host_model_inst.wr(`CGID_OFF_PARAM, {20'h0, h[3:0] - 4'h1, s}, 4'hf);
    cgid_host_model_inst.wr(`CGID_OFF_CMD, 32'h91, 4'h1);
    if (stray) cgid_host_model_inst.wr(`CGID_OFF_PARAM, 32'h109, 4'hf);
    repeat (2) @(posedge clk_i);
    while (busy !== 1'b0) @(posedge clk_i);
  endtask
  task automatic geo(input [15:0] h, input [15:0] s);
    reg [31:0] c, cap;
    c = LBA / ({16'h0, h} * {16'h0, s});
    if (c > 32'd65535) c = 32'd65535;
    cap = c * h * s;
    idw(8'd1, LBA / 32'd1008, 32'hffff);
    idw(8'd3, 32'd16, 32'hffff);
    idw(8'd6, 32'd63, 32'hffff);
    idw(8'd53, 32'h1, 32'h1);
    idw(8'd54, c, 32'hffff);
    idw(8'd55, {16'h0, h}, 32'hffff);
    idw(8'd56, {16'h0, s}, 32'hffff);
    idw(8'd57, cap, 32'hffff);
    idw(8'd58, cap >> 16, 32'hffff);
    idw(8'd60, LBA, 32'hffff);
    idw(8'd61, LBA >> 16, 32'hffff);
  endtask
  task automatic ref_cls(input [7:0] op, output [31:0] e, output [31:0] m);
    reg [4:0] c;
    reg [7:0] cn;
    cn = op;
    m = 32'h0000ff3f;
    casez (op)
      8'h00: c = 5'd2;
      8'h1?: begin c = 5'd3; cn = 8'h10; end
      8'h7?: begin c = 5'd6; cn = 8'h70; end
      8'h20, 8'h21, 8'h22, 8'h23: c = 5'd4;
      8'h30, 8'h31, 8'h32, 8'h33: c = 5'd5;
      8'h91: c = 5'd7;
      8'hec: c = 5'd8;
      8'hc4, 8'hc5, 8'hc6: c = 5'd9;
      8'hc8, 8'hc9, 8'hca, 8'hcb: c = 5'd10;
      8'h94, 8'h95, 8'h96, 8'h97: begin c = 5'd11; cn = op + 8'h4c; end
      8'h98, 8'h99: begin c = 5'd11; cn = op + 8'h4d; end
      8'he0, 8'he1, 8'he2, 8'he3, 8'he5, 8'he6: c = 5'd11;
      8'h8?, 8'h9a, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hf?: c = 5'd1;
      8'h3c, 8'h40, 8'h41, 8'h50, 8'h90, 8'h92, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hdf,
      8'he4, 8'he8, 8'he9, 8'hea, 8'heb, 8'hed, 8'hee, 8'hef: c = 5'd12;
      8'h08, 8'ha0, 8'ha1, 8'ha2: begin c = 5'd12; m = 32'h0; end
      default: c = 5'd0;
    endcase
    // Only read, write and DMA codes carry the no-retry variant bit
    if (c != 5'd4 && c != 5'd5 && c != 5'd10) m[5] = 1'b0;
    if (c <= 5'd1) m[15:8] = 8'h00;
    e = {16'h0, cn, 2'b00, op[0], c};
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    wrap_up;
  end
  initial begin
    reg [31:0] e, m;
    reg [15:0] h, s;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(`CGID_OFF_STATUS, 32'h4, 32'hffffffff);
    cgid_host_model_inst.wr(8'h20, 32'hffffffff, 4'hf);
    chk(8'h20, 32'h0, 32'hffffffff);
    geo(16'd16, 16'd63);
    for (int i = 0; i < 256; i++) begin
      if (i == 8'h91) continue;
      ref_cls(i[7:0], e, m);
      cgid_host_model_inst.wr(`CGID_OFF_CMD, i, 4'h1);
      chk(`CGID_OFF_CLASS, e, m);
      if (m[4:0] != 5'd0) cmp({31'h0, err}, {31'h0, e[4:0] == 5'd0}, 32'h1);
    end
    init(16'd4, 8'd255, 1'b1);
    geo(16'd4, 16'd255);
    init(16'd1, 8'd1, 1'b0);
    geo(16'd1, 16'd1);
    chk(`CGID_OFF_STATUS, 32'hc, 32'hffffffff);
    repeat (2) begin
      seed = lfsr(seed);
      h = {12'h0, seed[3:0]} + 16'd1;
      s = (seed[15:8] == 8'h0) ? 16'd1 : {8'h0, seed[15:8]};
      init(h, s[7:0], 1'b0);
      cgid_host_model_inst.wr(`CGID_OFF_CMD, 32'h6a, 4'h1);
      chk(`CGID_OFF_STATUS, 32'h1d, 32'hffffffff);
      geo(h, s);
    end
    init(16'd8, 8'd0, 1'b0);
    idw(8'd53, 32'h0, 32'h1);
    for (int w = 54; w < 59; w++) idw(w[7:0], 32'h0, 32'hffff);
    chk(`CGID_OFF_STATUS, 32'h0, 32'h4);
    init(16'd16, 8'd63, 1'b0);
    geo(16'd16, 16'd63);
    wrap_up;
  end
endmodule // tb_top
bind cgid_geom cgid_geom_asserts cgid_geom_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .busy_o(busy_o), .err_o(err_o));
